// File: hw/qdr_chan_mem.sv
// per-channel code and powerdown store, two read ports
`timescale 1ns/1ps
module qdr_chan_mem #(
	parameter int NUM_CH = qdr_pkg::NUM_CH,
	parameter int IDX_W  = 2
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	// write port
	input  wire logic                  wr_en,
	input  wire logic [IDX_W-1:0]      wr_idx,
	input  qdr_pkg::qdr_chan_s         wr_data,
	// read ports
	input  wire logic [IDX_W-1:0]      rd_a_idx,
	output qdr_pkg::qdr_chan_s         rd_a_data,
	input  wire logic [IDX_W-1:0]      rd_b_idx,
	output qdr_pkg::qdr_chan_s         rd_b_data
);
	qdr_pkg::qdr_chan_s mem_reg [NUM_CH];

	if (NUM_CH < 1 || NUM_CH > (1 << IDX_W)) begin : g_chk
		$error("channel count does not fit index width");
	end

	// ======================================================
	// reset clears every code, as at power on
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (ce && wr_en) begin
			mem_reg[wr_idx] <= wr_data;
		end
	end

	assign rd_a_data = mem_reg[rd_a_idx];
	assign rd_b_data = mem_reg[rd_b_idx];
endmodule : qdr_chan_mem

// File: hw/qdr_line_mon.sv
// bus line monitor: clock edges, start and stop conditions
`timescale 1ns/1ps
module qdr_line_mon (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// bus lines
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	// decoded events
	output qdr_pkg::qdr_line_s     line_o
);
	logic scl_q;
	logic sda_q;

	// ======================================================
	// previous levels, idle bus is high
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else if (ce) begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// ======================================================
	// data changing under a high clock marks a condition
	assign line_o.scl_rise = ce & ~scl_q & scl_i;
	assign line_o.scl_fall = ce & scl_q & ~scl_i;
	assign line_o.start    = ce & scl_q & scl_i & sda_q & ~sda_i;
	assign line_o.stop     = ce & scl_q & scl_i & ~sda_q & sda_i;
endmodule : qdr_line_mon

// File: hw/qdr_readback.sv
// two-wire slave transmitter readback path with wishbone registers
`timescale 1ns/1ps
module qdr_readback #(
	parameter int NUM_CH = qdr_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// address select pins
	input  wire logic        pin_address_hi,
	input  wire logic        pin_address_lo,
	// serial bus
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n
);
	// the channel field of the control byte is two bits wide
	if (NUM_CH != 4) begin : g_chk
		$error("readback needs exactly four channels");
	end
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CTRL, ST_ACK, ST_TX, ST_MACK, ST_WAIT
	} qdr_state_e;
	// ======================================================
	// decode helpers
	function automatic logic addr_hit(input logic [7:0] b,
		input logic hi, input logic lo);
		return b[7:1] == {qdr_pkg::SLV_ADDR_HI, hi, lo};
	endfunction : addr_hit
	function automatic logic [7:0] tx_byte(input logic [1:0] idx,
		input qdr_pkg::qdr_chan_s ent);
		unique case (idx)
			qdr_pkg::BYTE_PD: return {ent.pd, qdr_pkg::PD_FILL};
			qdr_pkg::BYTE_HI: return ent.code[11:4];
			default:          return {ent.code[3:0], qdr_pkg::LO_FILL};
		endcase
	endfunction : tx_byte
	// ======================================================
	// state
	qdr_state_e          state_reg;
	qdr_state_e          ack_next_reg;
	logic [7:0]          rx_reg;
	logic [7:0]          tx_reg;
	logic [3:0]          bit_reg;
	logic [7:0]          ctrl_reg;
	logic                ctrl_ok_reg;
	logic [1:0]          idx_reg;
	logic                mack_reg;
	logic                sda_oe_n_reg;
	logic                sda_o_reg;
	logic                done_reg;
	logic                en_reg;
	logic                ack_reg;
	logic [31:0]         dat_reg;
	qdr_pkg::qdr_line_s  ln;
	qdr_pkg::qdr_chan_s  ent_b;
	qdr_pkg::qdr_chan_s  ent_a;
	qdr_pkg::qdr_chan_s  wr_ent;
	logic                rx_full;
	logic                hit;
	logic [1:0]          first_idx;
	logic [1:0]          load_idx;
	logic [7:0]          load_byte;
	logic                done_set;
	logic                wb_go;
	logic [7:0]          chan_off;
	logic                chan_hit;
	logic [1:0]          rd_b_idx;
	logic [31:0]         rd_mux;
	// ======================================================
	// line events and channel store
	qdr_line_mon u_mon (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.line_o  (ln)
	);
	qdr_chan_mem #(.NUM_CH(NUM_CH), .IDX_W(2)) u_mem (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.ce        (ce),
		.wr_en     (wb_go && wb_we_i && chan_hit),
		.wr_idx    (chan_off[3:2]),
		.wr_data   (wr_ent),
		.rd_a_idx  (chan_off[3:2]),
		.rd_a_data (ent_a),
		.rd_b_idx  (rd_b_idx),
		.rd_b_data (ent_b)
	);
	// ======================================================
	// serial decode
	assign rx_full = bit_reg == qdr_pkg::RX_BITS;
	assign hit = en_reg && addr_hit(rx_reg, pin_address_hi,
		pin_address_lo);
	assign rd_b_idx = ctrl_reg[qdr_pkg::SEL_MSB:qdr_pkg::SEL_LSB];
	// start byte: extent bit picks two or three bytes
	assign first_idx = ctrl_reg[qdr_pkg::EXT_BIT] ? qdr_pkg::BYTE_PD
		: qdr_pkg::BYTE_HI;
	assign load_idx = (state_reg == ST_ACK) ? first_idx
		: idx_reg + 2'h1;
	assign load_byte = tx_byte(load_idx, ent_b);
	assign done_set = ln.scl_fall && state_reg == ST_MACK
		&& idx_reg == qdr_pkg::BYTE_LO;
	// ======================================================
	// serial state machine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg    <= ST_IDLE;
			ack_next_reg <= ST_WAIT;
			rx_reg       <= 8'h00;
			tx_reg       <= 8'h00;
			bit_reg      <= 4'h0;
			ctrl_reg     <= 8'h00;
			ctrl_ok_reg  <= 1'h0;
			idx_reg      <= 2'h0;
			mack_reg     <= 1'h0;
			sda_oe_n_reg <= 1'h1;
		end else if (ce) begin
			if (ln.stop) begin
				state_reg    <= ST_IDLE;
				ctrl_ok_reg  <= 1'h0;
				sda_oe_n_reg <= 1'h1;
			end else if (ln.start) begin
				// repeated start keeps the control byte
				state_reg    <= ST_ADDR;
				bit_reg      <= 4'h0;
				sda_oe_n_reg <= 1'h1;
			end else begin
				unique case (state_reg)
					ST_IDLE, ST_WAIT: begin
					end
					ST_ADDR, ST_CTRL: begin
						if (ln.scl_rise) begin
							rx_reg  <= {rx_reg[6:0], sda_i};
							bit_reg <= bit_reg + 4'h1;
						end else if (ln.scl_fall && rx_full) begin
							if (state_reg == ST_CTRL) begin
								ctrl_reg     <= rx_reg;
								ctrl_ok_reg  <= 1'h1;
								ack_next_reg <= ST_WAIT;
								state_reg    <= ST_ACK;
								sda_oe_n_reg <= 1'h0;
							end else if (hit && (!rx_reg[0] ||
								ctrl_ok_reg)) begin
								ack_next_reg <= rx_reg[0] ? ST_TX
									: ST_CTRL;
								state_reg    <= ST_ACK;
								sda_oe_n_reg <= 1'h0;
							end else begin
								state_reg <= ST_WAIT;
							end
						end
					end
					ST_ACK: begin
						if (ln.scl_fall) begin
							bit_reg   <= 4'h0;
							state_reg <= ack_next_reg;
							if (ack_next_reg == ST_TX) begin
								idx_reg      <= first_idx;
								tx_reg       <= load_byte;
								sda_oe_n_reg <= load_byte[7];
							end else begin
								sda_oe_n_reg <= 1'h1;
							end
						end
					end
					ST_TX: begin
						if (ln.scl_fall) begin
							if (bit_reg == qdr_pkg::TX_LAST) begin
								state_reg    <= ST_MACK;
								bit_reg      <= 4'h0;
								sda_oe_n_reg <= 1'h1;
							end else begin
								tx_reg       <= {tx_reg[6:0], 1'h0};
								bit_reg      <= bit_reg + 4'h1;
								sda_oe_n_reg <= tx_reg[6];
							end
						end
					end
					ST_MACK: begin
						if (ln.scl_rise) begin
							mack_reg <= ~sda_i;
						end else if (ln.scl_fall) begin
							if (mack_reg &&
								idx_reg != qdr_pkg::BYTE_LO) begin
								idx_reg      <= load_idx;
								tx_reg       <= load_byte;
								sda_oe_n_reg <= load_byte[7];
								state_reg    <= ST_TX;
							end else begin
								state_reg <= ST_WAIT;
							end
						end
					end
				endcase
			end
		end
	end
	// open drain: only ever pulls low
	always_ff @(posedge clk) begin
		sda_o_reg <= 1'h0;
	end
	// ======================================================
	// completion flag, a new completion beats a clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_reg <= 1'h0;
		end else if (ce) begin
			if (done_set) begin
				done_reg <= 1'h1;
			end else if (wb_go && wb_we_i && wb_adr_i ==
				qdr_pkg::REG_STAT && wb_sel_i[1] &&
				wb_dat_i[qdr_pkg::STAT_DONE]) begin
				done_reg <= 1'h0;
			end
		end
	end
	// ======================================================
	// wishbone decode
	assign wb_go    = wb_cyc_i && wb_stb_i && !ack_reg;
	assign chan_off = wb_adr_i - qdr_pkg::REG_CHAN0;
	assign chan_hit = wb_adr_i >= qdr_pkg::REG_CHAN0 &&
		wb_adr_i < qdr_pkg::REG_STAT && wb_adr_i[1:0] == 2'h0;
	always_comb begin
		wr_ent = ent_a;
		if (wb_sel_i[0]) begin
			wr_ent.code[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			wr_ent.code[11:8] = wb_dat_i[11:8];
		end
		if (wb_sel_i[2]) begin
			wr_ent.pd = wb_dat_i[17:16];
		end
	end
	always_comb begin
		rd_mux = 32'h0;
		if (chan_hit) begin
			rd_mux[11:0] = ent_a.code;
			rd_mux[17:16] = ent_a.pd;
		end else if (wb_adr_i == qdr_pkg::REG_CTRL) begin
			rd_mux[qdr_pkg::CTRL_EN_BIT] = en_reg;
		end else if (wb_adr_i == qdr_pkg::REG_STAT) begin
			rd_mux[7:0] = ctrl_reg;
			rd_mux[qdr_pkg::STAT_BUSY] = state_reg != ST_IDLE;
			rd_mux[qdr_pkg::STAT_DONE] = done_reg;
		end
	end
	// one wait state; unmapped reads give zero, writes vanish
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_reg <= 1'h0;
			dat_reg <= 32'h0;
		end else if (ce) begin
			ack_reg <= wb_go;
			if (wb_go && !wb_we_i) begin
				dat_reg <= rd_mux;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en_reg <= qdr_pkg::CTRL_EN_RST;
		end else if (ce && wb_go && wb_we_i && wb_sel_i[0] &&
			wb_adr_i == qdr_pkg::REG_CTRL) begin
			en_reg <= wb_dat_i[qdr_pkg::CTRL_EN_BIT];
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign sda_o    = sda_o_reg;
	assign sda_oe_n = sda_oe_n_reg;
	// ======================================================
	// checks
	a_addr_ack_drive: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_ADDR && ln.scl_fall && rx_full && hit
			&& !rx_reg[0])
		|=> (state_reg == ST_ACK && !sda_oe_n_reg
			&& ack_next_reg == ST_CTRL))
		else $error("write address not acknowledged");
	a_ctrl_capture: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_CTRL && ln.scl_fall && rx_full)
		|=> (state_reg == ST_ACK && !sda_oe_n_reg
			&& ctrl_reg == $past(rx_reg)))
		else $error("control byte not taken and acked");
	a_read_takeover: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_ACK && ln.scl_fall
			&& ack_next_reg == ST_TX)
		|=> (state_reg == ST_TX && bit_reg == 4'h0
			&& sda_oe_n_reg == $past(load_byte[7])))
		else $error("read ack not followed by transmit");
	a_two_bytes: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_ACK && ln.scl_fall
			&& ack_next_reg == ST_TX && !ctrl_reg[0])
		|=> idx_reg == qdr_pkg::BYTE_HI)
		else $error("short readback does not begin high");
	a_three_bytes: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_ACK && ln.scl_fall
			&& ack_next_reg == ST_TX && ctrl_reg[0])
		|=> idx_reg == qdr_pkg::BYTE_PD)
		else $error("long readback does not begin powerdown");
	a_chan_select: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_TX) |-> (rd_b_idx == ctrl_reg[2:1]
			&& $stable(ctrl_reg)))
		else $error("channel changed during readback");
	a_pd_fill: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_TX && bit_reg == 4'h0
			&& idx_reg == qdr_pkg::BYTE_PD)
		|-> tx_reg[5:0] == qdr_pkg::PD_FILL)
		else $error("powerdown byte low bits not ones");
	a_pd_mode: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_TX && bit_reg == 4'h0
			&& idx_reg == qdr_pkg::BYTE_PD)
		|-> tx_reg[7:6] == ent_b.pd)
		else $error("powerdown mode bits wrong");
	a_hi_byte: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_TX && bit_reg == 4'h0
			&& idx_reg == qdr_pkg::BYTE_HI)
		|-> tx_reg == ent_b.code[11:4])
		else $error("high byte wrong");
	a_lo_byte: assert property (
		@(posedge clk) disable iff (sys_rst)
		(state_reg == ST_TX && bit_reg == 4'h0
			&& idx_reg == qdr_pkg::BYTE_LO)
		|-> tx_reg[7:4] == ent_b.code[3:0])
		else $error("low byte wrong");
	a_addr_match: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_ADDR && ln.scl_fall && rx_full && !hit)
		|=> (state_reg == ST_WAIT && sda_oe_n_reg))
		else $error("foreign address answered");
	a_nack_release: assert property (
		@(posedge clk) disable iff (sys_rst)
		(ce && state_reg == ST_MACK && ln.scl_fall && !mack_reg)
		|=> (state_reg == ST_WAIT && sda_oe_n_reg)[*2])
		else $error("line held after nack");
endmodule : qdr_readback

// File: shared/qdr_pkg.sv
// constants and carrier types of the quad dac readback slave
// Functional notes
// - device acks matching address byte low
// - control byte follows, device acknowledges it
// - device acks read address, then transmits
// - extent bit 0: high then low byte
// - extent bit 1: powerdown, high, low
// - channel select bits choose readback channel
// - powerdown byte: mode bits, six ones
// - high byte carries code bits 11..4
// - low byte: code bits 3..0 on top
// - 7-bit address, two bits from pins
// - two mode bits encode four powerdown modes
package qdr_pkg;
	// ======================================================
	// serial link
	localparam logic [4:0] SLV_ADDR_HI = 5'h13;
	localparam logic [3:0] RX_BITS     = 4'h8;
	localparam logic [3:0] TX_LAST     = 4'h7;
	localparam int         EXT_BIT     = 0;
	localparam int         SEL_LSB     = 1;
	localparam int         SEL_MSB     = 2;
	localparam logic [1:0] BYTE_PD     = 2'h0;
	localparam logic [1:0] BYTE_HI     = 2'h1;
	localparam logic [1:0] BYTE_LO     = 2'h2;
	localparam logic [5:0] PD_FILL     = 6'h3f;
	localparam logic [3:0] LO_FILL     = 4'h0;
	// powerdown mode codes, both ends of the range are open circuit
	localparam logic [1:0] PD_HIZ      = 2'h0;
	localparam logic [1:0] PD_1K       = 2'h1;
	localparam logic [1:0] PD_100K     = 2'h2;
	localparam logic [1:0] PD_HIZ_ALT  = 2'h3;
	// ======================================================
	// channel store
	localparam int         NUM_CH      = 4;
	localparam int         CODE_W      = 12;
	// ======================================================
	// register map
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CHAN0   = 8'h04;
	localparam logic [7:0] REG_STAT    = 8'h14;
	localparam int         CTRL_EN_BIT = 0;
	localparam logic       CTRL_EN_RST = 1'h1;
	localparam int         CHAN_PD_LSB = 16;
	localparam int         STAT_BUSY   = 8;
	localparam int         STAT_DONE   = 9;
	// ======================================================
	// carriers
	typedef struct packed {
		logic [1:0]        pd;
		logic [CODE_W-1:0] code;
	} qdr_chan_s;
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} qdr_line_s;
endpackage : qdr_pkg

// File: tb/qdr_bus_master.sv
// two-wire bus master model for readback transfers
`timescale 1ns/1ps
module qdr_bus_master (
	// clock
	input  wire logic clk,
	// bus lines, sda_m is open drain: 1 releases
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	// ======================================================
	// bus phases
	// five clocks per half period, above the four the slave needs
	localparam int HALF = 5;
	initial begin
		scl = 1'h1;
		sda_m = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic bus_start();
		@(posedge clk);
		sda_m <= 1'h1;
		tick(HALF);
		scl <= 1'h1;
		tick(HALF);
		sda_m <= 1'h0;
		tick(HALF);
		scl <= 1'h0;
	endtask : bus_start
	task automatic bus_stop();
		@(posedge clk);
		sda_m <= 1'h0;
		tick(HALF);
		scl <= 1'h1;
		tick(HALF);
		sda_m <= 1'h1;
		tick(HALF);
	endtask : bus_stop
	// data changes only while scl is low, sampled late in high phase
	task automatic bit_xfer(input logic b, output logic r);
		@(posedge clk);
		sda_m <= b;
		tick(HALF);
		scl <= 1'h1;
		tick(HALF - 1);
		@(negedge clk);
		r = sda;
		@(posedge clk);
		scl <= 1'h0;
	endtask : bit_xfer
	// byte msb first, then ack slot
	task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack_seen);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
			q[i] = r;
		end
		bit_xfer(ack_in, ack_seen);
	endtask : byte_xfer
endmodule : qdr_bus_master

// File: tb/quad_dac_i2c_readback_test.sv
// self-checking bench of the readback slave and its registers
`timescale 1ns/1ps
module quad_dac_i2c_readback_test;
	// ======================================================
	// signals
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin_hi;
	logic        pin_lo;
	logic        scl;
	logic        sda_m;
	logic        sda_o;
	logic        sda_oe_n;
	wire logic   sda;
	int          err_total;
	int          checked;
	logic [7:0]  q;
	logic        ak;
	logic [31:0] rd;
	logic [11:0] code_tab [4];
	// wired and of master and slave pull-downs
	assign sda = sda_m & (sda_oe_n | sda_o);
	initial clk = 1'h0;
	always #10 clk = ~clk;
	// ======================================================
	// instances
	qdr_readback #(.NUM_CH(4)) uut (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pin_address_hi(pin_hi), .pin_address_lo(pin_lo),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);
	qdr_bus_master pm (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
	// ======================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	// one classic cycle, held until ack is sampled
	task automatic wb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		@(posedge clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		// no cycle count assumed: the wait ends on ack, with only the watchdog as timeout
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'h1);
		r = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb_xfer
	function automatic logic [7:0] addr_byte(input logic rd_n);
		return {qdr_pkg::SLV_ADDR_HI, pin_hi, pin_lo, rd_n};
	endfunction : addr_byte
	// single address byte, expecting the given ack level
	task automatic probe(input logic [7:0] a, input logic exp_ak);
		pm.bus_start();
		pm.byte_xfer(a, 1'h1, q, ak);
		check(ak, exp_ak);
		pm.bus_stop();
	endtask : probe
	task automatic readback(input int ch, input logic ext);
		pm.bus_start();
		pm.byte_xfer(addr_byte(1'h0), 1'h1, q, ak);
		check(ak, 32'h0);
		pm.byte_xfer({5'h00, ch[1:0], ext}, 1'h1, q, ak);
		check(ak, 32'h0);
		pm.bus_start();
		pm.byte_xfer(addr_byte(1'h1), 1'h1, q, ak);
		check(ak, 32'h0);
		if (ext) begin
			pm.byte_xfer(8'hff, 1'h0, q, ak);
			check(q, {ch[1:0], 6'h3f});
		end
		pm.byte_xfer(8'hff, 1'h0, q, ak);
		check(q, code_tab[ch][11:4]);
		pm.byte_xfer(8'hff, 1'h1, q, ak);
		check(q[7:4], code_tab[ch][3:0]);
		// slave sees the nack clock fall one edge later, so look after it
		repeat (2) @(negedge clk);
		check(sda_oe_n, 32'h1);
	endtask : readback
	// ======================================================
	// main sequence
	initial begin
		err_total = 0;
		checked = 0;
		sys_rst = 1'h1;
		ce = 1'h1;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		pin_hi = 1'h0;
		pin_lo = 1'h0;
		code_tab = '{12'h5a3, 12'hc0f, 12'h3e1, 12'h896};
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		@(negedge clk);
		check(sda_oe_n, 32'h1);
		// ce low freezes the register bus: no ack until it returns
		@(posedge clk);
		ce <= 1'h0;
		fork
			wb_xfer(1'h0, qdr_pkg::REG_CTRL, 32'h0, 4'hf, rd);
			begin
				repeat (3) @(posedge clk);
				check(wb_ack_o, 32'h0);
				ce <= 1'h1;
			end
		join
		check(rd, 32'h1);
		// channel code from code_tab, powerdown mode equal to the index
		for (int c = 0; c < 4; c++) begin
			wb_xfer(1'h1, qdr_pkg::REG_CHAN0 + 8'(4 * c),
				{14'h0, 2'(c), 4'h0, code_tab[c]}, 4'h7, rd);
		end
		wb_xfer(1'h1, 8'h40, 32'hffffffff, 4'hf, rd);
		wb_xfer(1'h0, 8'h40, 32'h0, 4'hf, rd);
		check(rd, 32'h0);
		// pins follow the channel, both extents back to back
		for (int c = 0; c < 4; c++) begin
			pin_hi <= c[1];
			pin_lo <= c[0];
			readback(c, 1'h0);
			readback(c, 1'h1);
			pm.bus_stop();
		end
		wb_xfer(1'h0, qdr_pkg::REG_STAT, 32'h0, 4'hf, rd);
		check(rd, 32'h207);
		wb_xfer(1'h1, qdr_pkg::REG_STAT, 32'h200, 4'h2, rd);
		wb_xfer(1'h0, qdr_pkg::REG_STAT, 32'h0, 4'hf, rd);
		check(rd, 32'h007);
		pin_hi <= 1'h0;
		pin_lo <= 1'h0;
		probe({qdr_pkg::SLV_ADDR_HI, 2'h3, 1'h0}, 1'h1);
		probe(addr_byte(1'h1), 1'h1);
		wb_xfer(1'h1, qdr_pkg::REG_CTRL, 32'h0, 4'hf, rd);
		probe(addr_byte(1'h0), 1'h1);
		wb_xfer(1'h1, qdr_pkg::REG_CTRL, 32'h1, 4'hf, rd);
		probe(addr_byte(1'h0), 1'h0);
		tally_and_finish();
	end
	// watchdog, several times the expected run
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
endmodule : quad_dac_i2c_readback_test
